// *** bit_probe.sv ***
// Selects the tested operand bit and folds it into the status flags
`timescale 1ns/10ps
module bit_probe
  import bit_test_pkg::*;
(
  input  wire logic [15:0] operand,
  input  wire logic [15:0] select_word,
  input  wire logic        dest_zero,
  input  wire logic [15:0] flags_in,
  output logic      [15:0] flags_out,
  output logic             tested_bit
);

  logic [BITSEL_W-1:0] pos;

  // Upper bits of the select word are don't-care
  assign pos = select_word[BITSEL_W-1:0];
  // Position 0 is the LSB, 15 the MSB
  assign tested_bit = operand[pos];

  always_comb
  begin
    // Only the chosen destination flag moves
    flags_out = flags_in;
    if (dest_zero)
    begin
      flags_out[SR_Z] = ~tested_bit;
    end
    else
    begin
      flags_out[SR_C] = tested_bit;
    end
  end

endmodule

// *** bit_test_monitor.sv ***
// Assertions on the APB port behaviour of the bit test unit
`timescale 1ns/10ps
module bit_test_monitor
  import bit_test_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence rd_done_s;
    pready && !pwrite;
  endsequence

  answer_delay_a: assert property (access_s |=> pready)
    else $error("no answer one cycle after access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without access phase");
  error_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad pslverr or data on refused access");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  data_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved between accesses");
  word_only_a: assert property ((rd_done_s and (paddr[11:2] != OFS_INSTR[11:2])) |->
    prdata[31:16] == 16'h0)
    else $error("upper half of word register not zero");
  status_code_a: assert property ((rd_done_s and (paddr[11:2] == OFS_STATUS[11:2])) |->
    prdata[31:2] == 30'h0 && (prdata[0] || !prdata[1]))
    else $error("status read malformed");
endmodule

// *** bit_test_pkg.sv ***
// Shared constants and types for the variable-position bit test execution block
package bit_test_pkg;

  localparam int unsigned DATA_W    = 16;
  localparam int unsigned INSTR_W   = 24;
  localparam int unsigned NUM_WREG  = 16;
  localparam int unsigned MEM_WORDS = 64;
  localparam int unsigned MEM_AW    = 6;
  localparam int unsigned BITSEL_W  = 4;
  localparam int unsigned PADDR_W   = 12;

  // Register map (byte addresses)
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_INSTR  = 12'h004;
  localparam logic [11:0] OFS_FLAGS  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [5:0]  WREG_PAGE  = 6'h01;
  localparam logic [3:0]  MEM_PAGE   = 4'h4;

  // Register fields
  localparam int unsigned CTRL_GO        = 0;
  localparam int unsigned STATUS_DONE    = 1'h0;
  localparam int unsigned STATUS_ILLEGAL = 1;
  localparam int unsigned SR_C           = 0;
  localparam int unsigned SR_Z           = 1;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;

  // Instruction word layout
  localparam logic [7:0]  OPCODE    = 8'ha5;
  localparam int unsigned OPC_HI    = 23;
  localparam int unsigned OPC_LO    = 16;
  localparam int unsigned DEST_BIT  = 15;
  localparam int unsigned WSEL_HI   = 14;
  localparam int unsigned WSEL_LO   = 11;
  localparam int unsigned PAD_HI    = 10;
  localparam int unsigned PAD_LO    = 7;
  localparam int unsigned MODE_HI   = 6;
  localparam int unsigned MODE_LO   = 4;
  localparam int unsigned SRC_HI    = 3;
  localparam int unsigned SRC_LO    = 0;
  localparam logic [3:0]  PAD_ZERO  = 4'h0;

  localparam logic [15:0] PTR_STEP  = 16'h0002;

  typedef enum logic [2:0] {
    MODE_DIRECT  = 3'b000,
    MODE_IND     = 3'b001,
    MODE_POSTDEC = 3'b010,
    MODE_POSTINC = 3'b011,
    MODE_PREDEC  = 3'b100,
    MODE_PREINC  = 3'b101
  } addr_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } fsm_e;

  typedef struct packed {
    logic                valid;
    logic                dest_zero;
    logic [3:0]          bit_reg;
    logic [2:0]          mode;
    logic [3:0]          src_reg;
  } decoded_s;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] ptr_next;
    logic        ptr_write;
    logic        indirect;
    logic        bad_mode;
  } addr_res_s;

endpackage

// *** bit_test_variable_position.sv ***
// Execution unit for the bit test with register-selected bit position, behind APB
// Function
// - carry form copies tested bit into carry
// - zero form writes inverted bit into zero
// - source operand is never modified
// - bit position uses only select register low nibble
// - position zero is LSB, fifteen MSB
// - operand direct from register or indirect memory
// - one instruction bit picks carry or zero
// - opcode 1010 0101, select register from w
// - addressing mode taken from p field
// - source register taken from s field
// - word operands only, no byte form
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module bit_test_variable_position
  import bit_test_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr
);

  typedef struct packed {
    fsm_e                                st;
    logic [NUM_WREG-1:0][DATA_W-1:0]     wreg;
    logic [MEM_WORDS-1:0][DATA_W-1:0]    mem;
    logic [DATA_W-1:0]                   flags;
    logic [INSTR_W-1:0]                  instr;
    logic                                done;
    logic                                illegal;
    logic                                pready;
    logic                                pslverr;
    logic [31:0]                         prdata;
  } state_s;

  state_s     s_q;
  state_s     s_d;
  decoded_s   dec;
  addr_res_s  ares;
  logic [15:0] src_ptr;
  logic [15:0] select_word;
  logic [15:0] operand;
  logic [15:0] flags_new;
  logic        access;
  logic [5:0]  wreg_page;
  logic [3:0]  mem_page;
  logic [3:0]  wreg_idx;
  logic [MEM_AW-1:0] mem_idx;
  logic [MEM_AW-1:0] ea_idx;

  // Instruction field decode
  always_comb
  begin
    dec           = '0;
    dec.valid     = (s_q.instr[OPC_HI:OPC_LO] == OPCODE) &&
                    (s_q.instr[PAD_HI:PAD_LO] == PAD_ZERO);
    dec.dest_zero = s_q.instr[DEST_BIT];
    dec.bit_reg   = s_q.instr[WSEL_HI:WSEL_LO];
    dec.mode      = s_q.instr[MODE_HI:MODE_LO];
    dec.src_reg   = s_q.instr[SRC_HI:SRC_LO];
  end

  assign src_ptr     = s_q.wreg[dec.src_reg];
  // Select word is read before any pointer update, even when it is the pointer
  assign select_word = s_q.wreg[dec.bit_reg];
  // Memory is word addressed; the byte bit of the pointer is dropped and high bits wrap
  assign ea_idx      = ares.ea[MEM_AW:1];
  // Whole 16-bit word fetched, never a byte lane
  assign operand     = ares.indirect ? s_q.mem[ea_idx] : src_ptr;

  operand_address_unit u_addr (
    .mode    (dec.mode),
    .pointer (src_ptr),
    .res     (ares)
  );

  bit_probe u_probe (
    .operand     (operand),
    .select_word (select_word),
    .dest_zero   (dec.dest_zero),
    .flags_in    (s_q.flags),
    .flags_out   (flags_new),
    .tested_bit  ()
  );

  // One wait state: answer registered so the bus outputs come from flops
  assign access    = psel & penable & ~s_q.pready;
  assign wreg_page = paddr[11:6];
  assign mem_page  = paddr[11:8];
  assign wreg_idx  = paddr[5:2];
  assign mem_idx   = paddr[7:2];

  always_comb
  begin
    s_d         = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    if (access)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      if (wreg_page == WREG_PAGE)
      begin
        if (pwrite)
        begin
          s_d.wreg[wreg_idx] = pwdata[DATA_W-1:0];
        end
        else
        begin
          s_d.prdata[DATA_W-1:0] = s_q.wreg[wreg_idx];
        end
      end
      else if (mem_page == MEM_PAGE)
      begin
        if (pwrite)
        begin
          s_d.mem[mem_idx] = pwdata[DATA_W-1:0];
        end
        else
        begin
          s_d.prdata[DATA_W-1:0] = s_q.mem[mem_idx];
        end
      end
      else
      begin
        case ({paddr[11:2], 2'b00})
          OFS_CTRL:
          begin
            // Go is a self-clearing strobe; reads show zero
            if (pwrite && pwdata[CTRL_GO] && (s_q.st == ST_IDLE))
            begin
              s_d.st      = ST_EXEC;
              s_d.done    = 1'b0;
              s_d.illegal = 1'b0;
            end
          end
          OFS_INSTR:
          begin
            if (pwrite)
            begin
              s_d.instr = pwdata[INSTR_W-1:0];
            end
            else
            begin
              s_d.prdata[INSTR_W-1:0] = s_q.instr;
            end
          end
          OFS_FLAGS:
          begin
            if (pwrite)
            begin
              s_d.flags = pwdata[DATA_W-1:0];
            end
            else
            begin
              s_d.prdata[DATA_W-1:0] = s_q.flags;
            end
          end
          OFS_STATUS:
          begin
            if (!pwrite)
            begin
              s_d.prdata[STATUS_DONE]    = s_q.done;
              s_d.prdata[STATUS_ILLEGAL] = s_q.illegal;
            end
          end
          default:
          begin
            s_d.pslverr = 1'b1;
          end
        endcase
      end
    end

    case (s_q.st)
      ST_IDLE:
      begin
        s_d.st = s_d.st;
      end
      ST_EXEC:
      begin
        // Whole instruction retires in this single cycle
        s_d.st   = ST_IDLE;
        s_d.done = 1'b1;
        if (!dec.valid || ares.bad_mode)
        begin
          // Unknown encoding: nothing architectural changes
          s_d.illegal = 1'b1;
        end
        else
        begin
          s_d.flags = flags_new;
          // Only the pointer moves; the tested word itself is never written
          if (ares.ptr_write)
          begin
            s_d.wreg[dec.src_reg] = ares.ptr_next;
          end
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.flags   <= FLAGS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule

// *** bit_test_variable_position_tb.sv ***
// Self-checking bench driving the bit test unit through APB
`timescale 1ns/10ps
module bit_test_variable_position_tb
  import bit_test_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          err_total, num_checks;
  logic [2:0]  m;
  logic [3:0]  s, b, pd;
  logic        z, ok, hit;
  logic [15:0] wv, bv, mv, fl, ef, p, ea, np, ws;
  logic [7:0]  opc;

  bit_test_variable_position u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Trailing idle cycle keeps psel from being assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] ed, input logic ee);
    exp_q.push_back({ee, ed});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed);
    xfer(1'b0, a, 32'h0, ed, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Falling edge keeps the compare clear of the design's own updates
  always @(negedge pclk)
    if (pready === 1'b1)
    begin
      e = exp_q.pop_front();
      chk("prdata", prdata, e[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
    end

  initial
  begin
    #100000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_total  = 0;
    num_checks = 0;
    void'($urandom(32'h215e48f7));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_FLAGS, 32'h0);
    xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    rd(OFS_CTRL, 32'h0);
    for (int i = 0; i < 48; i++)
    begin
      m   = 3'(i % 8);
      s   = 4'($urandom);
      b   = s + 4'($urandom_range(1, 15));
      z   = 1'($urandom);
      wv  = 16'($urandom);
      bv  = 16'($urandom);
      mv  = 16'($urandom);
      fl  = 16'($urandom);
      p   = wv & 16'hfffe;
      ws  = (m == MODE_DIRECT) ? wv : p;
      ea  = (m == MODE_PREDEC) ? p - PTR_STEP : (m == MODE_PREINC) ? p + PTR_STEP : p;
      np  = (m == MODE_POSTDEC || m == MODE_PREDEC) ? p - PTR_STEP :
            (m == MODE_POSTINC || m == MODE_PREINC) ? p + PTR_STEP : ws;
      opc = (i == 13) ? 8'ha3 : OPCODE;
      // A nonzero filler field must be refused like a foreign opcode
      pd  = (i == 29) ? 4'h8 : PAD_ZERO;
      ok  = m < 3'd6 && i != 13 && i != 29;
      hit = (m == MODE_DIRECT) ? wv[bv[3:0]] : mv[bv[3:0]];
      ef  = fl;
      if (ok && z)
        ef[SR_Z] = ~hit;
      else if (ok)
        ef[SR_C] = hit;
      wr({WREG_PAGE, s, 2'b00}, 32'(ws));
      wr({WREG_PAGE, b, 2'b00}, 32'(bv));
      wr({MEM_PAGE, ea[6:1], 2'b00}, 32'(mv));
      wr(OFS_FLAGS, 32'(fl));
      wr(OFS_INSTR, 32'({opc, z, b, pd, m, s}));
      wr(OFS_CTRL, 32'h1);
      rd(OFS_STATUS, ok ? 32'h1 : 32'h3);
      rd(OFS_FLAGS, 32'(ef));
      rd({WREG_PAGE, s, 2'b00}, 32'(ok ? np : ws));
      rd({MEM_PAGE, ea[6:1], 2'b00}, 32'(mv));
    end
    tally_and_finish();
  end
endmodule

bind bit_test_variable_position bit_test_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** operand_address_unit.sv ***
// Effective address and pointer update for the source operand modes
`timescale 1ns/10ps
module operand_address_unit
  import bit_test_pkg::*;
(
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] pointer,
  output addr_res_s        res
);

  always_comb
  begin
    res           = '0;
    res.ea        = pointer;
    res.ptr_next  = pointer;
    case (mode)
      MODE_DIRECT:
      begin
        res.indirect = 1'b0;
      end
      MODE_IND:
      begin
        res.indirect = 1'b1;
      end
      MODE_POSTDEC:
      begin
        res.indirect  = 1'b1;
        res.ptr_next  = pointer - PTR_STEP;
        res.ptr_write = 1'b1;
      end
      MODE_POSTINC:
      begin
        res.indirect  = 1'b1;
        res.ptr_next  = pointer + PTR_STEP;
        res.ptr_write = 1'b1;
      end
      MODE_PREDEC:
      begin
        res.indirect  = 1'b1;
        res.ptr_next  = pointer - PTR_STEP;
        res.ea        = pointer - PTR_STEP;
        res.ptr_write = 1'b1;
      end
      MODE_PREINC:
      begin
        res.indirect  = 1'b1;
        res.ptr_next  = pointer + PTR_STEP;
        res.ea        = pointer + PTR_STEP;
        res.ptr_write = 1'b1;
      end
      default:
      begin
        res.bad_mode = 1'b1;
      end
    endcase
  end

endmodule
